// ===== led_model.sv
`timescale 1ns/10ps
module led_model (
    input  wire logic core_clk,
    input  wire logic pwm_level,
    input  wire logic ind_level,
    input  wire logic ind_oe,
    output int        hi_cycles,
    output int        per_cycles,
    output logic      led_lit
);
    int   hi_cnt;
    int   per_cnt;
    logic pwm_d;

    // pull-down on the indicator line once the pin floats
    assign led_lit = ind_oe ? ind_level : 1'b0;

    // start from a dark lamp
    initial begin
        hi_cnt     = 0;
        per_cnt    = 0;
        pwm_d      = 1'b0;
        hi_cycles  = 0;
        per_cycles = 0;
    end

    // lit width and spacing of lit starts, in core cycles
    always @(posedge core_clk) begin
        pwm_d   <= pwm_level;
        hi_cnt  <= pwm_level ? hi_cnt + 1 : 0;
        per_cnt <= per_cnt + 1;
        if (pwm_d && !pwm_level) begin
            hi_cycles <= hi_cnt;
        end
        if (!pwm_d && pwm_level) begin
            per_cycles <= per_cnt;
            per_cnt    <= 1;
        end
    end
endmodule

// ===== master_interval_timer.sv
`timescale 1ns/10ps
module master_interval_timer
    import pwm_dimmer_pkg::*;
#(
    parameter logic [CNT_W-1:0] PERIOD_COUNT = 17'h0BB80
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic stop,
    input  wire logic tick,
    output logic      running,
    output logic      period_end
);
    typedef struct packed {
        logic             run;
        logic [CNT_W-1:0] cnt;
        logic             pend;
    } master_state_t;

    master_state_t s_reg;
    master_state_t s_next;

    // down counter, reload and one pulse at each period end
    always_comb begin
        s_next      = s_reg;
        s_next.pend = 1'b0;
        if (start) begin
            s_next.run = 1'b1;
            s_next.cnt = PERIOD_COUNT - 1'b1;
        end else if (stop) begin
            s_next.run = 1'b0;
        end else if (s_reg.run && tick) begin
            if (s_reg.cnt == '0) begin
                s_next.cnt  = PERIOD_COUNT - 1'b1;
                s_next.pend = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign running    = s_reg.run;
    assign period_end = s_reg.pend;
endmodule

// ===== pwm_dimmer.sv
`timescale 1ns/10ps
module pwm_dimmer
    import pwm_dimmer_pkg::*;
#(
    parameter int PERIOD_MS    = PWM_INTERVAL_MS,
    parameter int PERIOD_COUNT = TIMER_CLKS_PER_MS * PERIOD_MS,
    parameter int UPDATE_TICKS = TICKS_PER_UPDATE
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   pwm_out_pin,
    output logic                   indicator_port_pin,
    output logic                   indicator_oe,
    output logic                   master_period_irq,
    output logic                   irq
);
    // ------------------------------------------------------------
    // derived counts
    // ------------------------------------------------------------
    localparam int STEP_I = (PERIOD_COUNT / PCT_FULL) * INCREMENT_PCT;
    localparam int INIT_I = (PERIOD_COUNT / PCT_FULL) * INITIAL_PCT;
    localparam logic [CNT_W-1:0] PERIOD_C = CNT_W'(PERIOD_COUNT);
    localparam logic [CNT_W:0]   PERIOD_X = (CNT_W+1)'(PERIOD_COUNT);
    localparam logic [CNT_W-1:0] STEP_C   = CNT_W'(STEP_I);
    localparam logic [CNT_W-1:0] INIT_C   = CNT_W'(INIT_I);
    localparam logic [TICK_W-1:0] LAST_TICK = TICK_W'(UPDATE_TICKS - 1);
    localparam logic [ACC_W:0] TIMER_RATE = (ACC_W+1)'(TIMER_CLKS_PER_MS);
    localparam logic [ACC_W:0] CORE_RATE  = (ACC_W+1)'(CORE_CLK_KHZ);
    localparam longint PERIOD_CYCLES =
        longint'(PERIOD_COUNT) * CORE_CLK_KHZ / TIMER_CLKS_PER_MS;
    // divider phase makes some periods one core cycle longer
    localparam longint PERIOD_CYCLES_HI =
        (longint'(PERIOD_COUNT) * CORE_CLK_KHZ + TIMER_CLKS_PER_MS - 1)
        / TIMER_CLKS_PER_MS;

    // refuse values the counters cannot hold
    if (PERIOD_COUNT < PCT_FULL || PERIOD_COUNT >= (1 << CNT_W)
        || UPDATE_TICKS < 1 || UPDATE_TICKS > (1 << TICK_W)
        || PERIOD_CYCLES_HI > (1 << 20)) begin : g_bad
        $error("pwm_dimmer: period or update count out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        run_state_t        state;
        logic              start;
        logic              stop;
        logic [ACC_W-1:0]  acc;
        logic              tick;
        logic [TICK_W-1:0] ticks;
        logic [CNT_W-1:0]  compare;
        logic              led;
        logic              oe;
        logic [7:0]        dir;
        logic [IRQ_W-1:0]  status;
        logic [IRQ_W-1:0]  enable;
        logic              irq;
        logic [DATA_W-1:0] rd_data;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;
    logic       period_end;
    logic       master_run;
    logic       slave_trig;
    logic       pair_wr;
    logic       update;

    // address match, shared by write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    master_interval_timer #(
        .PERIOD_COUNT (PERIOD_C)
    ) u_master (
        .core_clk   (core_clk),
        .rst        (rst),
        .start      (s_reg.start),
        .stop       (s_reg.stop),
        .tick       (s_reg.tick),
        .running    (master_run),
        .period_end (period_end)
    );

    // slave restarts with the pair and at every master period end
    assign slave_trig = s_reg.start | period_end;

    slave_one_count u_slave (
        .core_clk (core_clk),
        .rst      (rst),
        .trigger  (slave_trig),
        .stop     (s_reg.stop),
        .tick     (s_reg.tick),
        .compare  (s_reg.compare),
        .pin      (pwm_out_pin)
    );

    // both start bits in the same write
    assign pair_wr = wr_en && hit(addr, CTRL_OFS)
                     && wr_data[MASTER_TRIG_BIT]
                     && wr_data[SLAVE_TRIG_BIT];
    assign update  = period_end && (s_reg.state == ST_RUN)
                     && (s_reg.ticks == LAST_TICK);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [ACC_W:0]   acc_sum;
        logic [CNT_W:0]   duty_sum;
        logic [IRQ_W-1:0] clr;
        logic [IRQ_W-1:0] set;
        acc_sum  = {1'b0, s_reg.acc} + TIMER_RATE;
        duty_sum = {1'b0, s_reg.compare} + {1'b0, STEP_C};
        clr      = '0;
        set      = '0;
        s_next         = s_reg;
        s_next.start   = 1'b0;
        s_next.stop    = 1'b0;
        s_next.tick    = 1'b0;
        s_next.rd_data = '0;

        // fractional divider: 24000 timer clocks per ms
        if (acc_sum >= CORE_RATE) begin
            s_next.acc  = ACC_W'(acc_sum - CORE_RATE);
            s_next.tick = 1'b1;
        end else begin
            s_next.acc = acc_sum[ACC_W-1:0];
        end

        // count master periods, step duty and indicator
        if (period_end && s_reg.state == ST_RUN) begin
            if (update) begin
                s_next.ticks = '0;
                s_next.led   = ~s_reg.led;
                if (duty_sum > PERIOD_X) begin
                    s_next.compare = INIT_C;
                end else begin
                    s_next.compare = duty_sum[CNT_W-1:0];
                end
            end else begin
                s_next.ticks = s_reg.ticks + 1'b1;
            end
        end

        // register writes
        if (wr_en) begin
            if (pair_wr) begin
                s_next.state   = ST_RUN;
                s_next.start   = 1'b1;
                s_next.acc     = '0;
                s_next.tick    = 1'b0;
                s_next.ticks   = '0;
                s_next.compare = INIT_C;
                s_next.enable[IRQ_PERIOD_BIT] = 1'b1;
            end else if (hit(addr, CTRL_OFS) && wr_data[STOP_BIT]) begin
                s_next.state = ST_IDLE;
                s_next.stop  = 1'b1;
            end
            if (hit(addr, CLEAR_OFS)) begin
                clr = wr_data[IRQ_W-1:0];
            end
            if (hit(addr, ENABLE_OFS) && !pair_wr) begin
                s_next.enable = wr_data[IRQ_W-1:0];
            end
            if (hit(addr, PORTDIR_OFS)) begin
                s_next.dir = wr_data[7:0];
            end
        end

        // sticky events, a new event beats a clear
        set[IRQ_PERIOD_BIT] = period_end;
        set[IRQ_UPDATE_BIT] = update;
        s_next.status = (s_reg.status & ~clr) | set;
        s_next.irq    = |(s_next.status & s_next.enable);
        s_next.oe     = ~s_next.dir[DIR_BIT];

        // register reads, data one cycle later
        if (rd_en) begin
            unique case (1'b1)
                hit(addr, CTRL_OFS):
                    s_next.rd_data = DATA_W'(s_reg.state == ST_RUN);
                hit(addr, STATUS_OFS):
                    s_next.rd_data = DATA_W'(s_reg.status);
                hit(addr, ENABLE_OFS):
                    s_next.rd_data = DATA_W'(s_reg.enable);
                hit(addr, PORTDIR_OFS):
                    s_next.rd_data = DATA_W'(s_reg.dir);
                hit(addr, DUTY_OFS):
                    s_next.rd_data = DATA_W'(s_reg.compare);
                hit(addr, TICK_OFS):
                    s_next.rd_data = DATA_W'(s_reg.ticks);
                default:
                    s_next.rd_data = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg         <= '0;
            s_reg.state   <= ST_IDLE;
            s_reg.compare <= INIT_C;
            s_reg.dir     <= PORTDIR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs from flip-flops
    assign rd_data            = s_reg.rd_data;
    assign indicator_port_pin = s_reg.led;
    assign indicator_oe       = s_reg.oe;
    assign master_period_irq  = period_end;
    assign irq                = s_reg.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    localparam logic [19:0] GAP_LAST = 20'(PERIOD_CYCLES - 1);
    localparam logic [19:0] GAP_LONG = 20'(PERIOD_CYCLES_HI - 1);
    logic [19:0] gap_cnt;
    logic        gap_seen;

    // cycles since the previous period end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_cnt  <= '0;
            gap_seen <= 1'b0;
        end else if (period_end) begin
            gap_cnt  <= '0;
            gap_seen <= !pair_wr;
        end else if (pair_wr || s_reg.stop) begin
            gap_cnt  <= '0;
            gap_seen <= 1'b0;
        end else begin
            gap_cnt  <= gap_cnt + 1'b1;
        end
    end

    sequence s_launch;
        ##1 (s_reg.start && s_reg.enable[IRQ_PERIOD_BIT])
        ##1 master_run;
    endsequence

    property p_period_gap;
        period_end && gap_seen |->
            (gap_cnt == GAP_LAST) || (gap_cnt == GAP_LONG);
    endproperty
    a_period_gap: assert property (p_period_gap)
        else $error("master period length wrong");

    property p_start_pair;
        $rose(s_reg.state == ST_RUN) |-> $past(pair_wr);
    endproperty
    a_start_pair: assert property (p_start_pair)
        else $error("run entered without paired start write");

    property p_unmask;
        pair_wr |-> s_launch;
    endproperty
    a_unmask: assert property (p_unmask)
        else $error("start did not unmask or launch master");

    property p_tick_wrap;
        update && !pair_wr |=> s_reg.ticks == '0
            && s_reg.status[IRQ_UPDATE_BIT];
    endproperty
    a_tick_wrap: assert property (p_tick_wrap)
        else $error("tick count did not wrap on update");

    property p_duty_step;
        update && !pair_wr |=>
            (s_reg.compare == $past(s_reg.compare) + STEP_C)
            || (s_reg.compare == INIT_C
                && $past(s_reg.compare) > PERIOD_C - STEP_C);
    endproperty
    a_duty_step: assert property (p_duty_step)
        else $error("duty did not step correctly");

    property p_led;
        update && !pair_wr |=>
            indicator_port_pin != $past(indicator_port_pin);
    endproperty
    a_led: assert property (p_led)
        else $error("indicator did not toggle on update");

    property p_dir;
        wr_en && hit(addr, PORTDIR_OFS) |=>
            indicator_oe == !$past(wr_data[DIR_BIT]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("indicator enable does not follow direction bit");

    property p_pwm_high;
        slave_trig && s_reg.compare != '0 && !s_reg.stop |=> pwm_out_pin;
    endproperty
    a_pwm_high: assert property (p_pwm_high)
        else $error("pwm pin not high at period start");

    property p_stop_low;
        s_reg.stop |=> !pwm_out_pin && !master_run;
    endproperty
    a_stop_low: assert property (p_stop_low)
        else $error("stop did not halt the channels");

    property p_set_wins;
        period_end && wr_en && hit(addr, CLEAR_OFS)
            && wr_data[IRQ_PERIOD_BIT] |=> s_reg.status[IRQ_PERIOD_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("period event lost to a clear");
endmodule

// ===== pwm_dimmer_pkg.sv
package pwm_dimmer_pkg;
    // ------------------------------------------------------------
    // clock and timer rates
    // ------------------------------------------------------------
    localparam int CORE_CLK_KHZ      = 200000;  // 5 ns period
    localparam int TIMER_CLKS_PER_MS = 24000;   // timer clock, kHz
    localparam int PWM_INTERVAL_MS   = 2;
    localparam int UPDATE_MS         = 500;
    localparam int TICKS_PER_UPDATE  = UPDATE_MS / PWM_INTERVAL_MS;
    localparam int INITIAL_PCT       = 10;
    localparam int INCREMENT_PCT     = 20;
    localparam int PCT_FULL          = 100;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W  = 17;
    localparam int ACC_W  = 18;
    localparam int TICK_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IRQ_W  = 2;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] CLEAR_OFS   = 8'h08;
    localparam logic [ADDR_W-1:0] ENABLE_OFS  = 8'h0C;
    localparam logic [ADDR_W-1:0] PORTDIR_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] DUTY_OFS    = 8'h14;
    localparam logic [ADDR_W-1:0] TICK_OFS    = 8'h18;
    localparam int MASTER_TRIG_BIT = 0;
    localparam int SLAVE_TRIG_BIT  = 1;
    localparam int STOP_BIT        = 2;
    localparam int IRQ_PERIOD_BIT  = 0;
    localparam int IRQ_UPDATE_BIT  = 1;
    localparam int DIR_BIT         = 0;
    localparam logic [7:0] PORTDIR_RESET = 8'hFF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } run_state_t;
endpackage

// ===== slave_one_count.sv
`timescale 1ns/10ps
module slave_one_count
    import pwm_dimmer_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             trigger,
    input  wire logic             stop,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] compare,
    output logic                  pin
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             out;
    } slave_state_t;

    slave_state_t s_reg;
    slave_state_t s_next;

    // one count: load on trigger, high for compare timer clocks
    always_comb begin
        s_next = s_reg;
        if (stop) begin
            s_next.out = 1'b0;
        end else if (trigger) begin
            s_next.cnt = compare;
            s_next.out = (compare != '0);
        end else if (s_reg.out && tick) begin
            s_next.cnt = s_reg.cnt - 1'b1;
            if (s_reg.cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                s_next.out = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin = s_reg.out;
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench
    import pwm_dimmer_pkg::*;
;
    // short period and update count keep the run brief
    localparam int PC     = 200;
    localparam int UT     = 3;
    localparam int INIT_C = PC / 100 * INITIAL_PCT;
    localparam int STEP_C = PC / 100 * INCREMENT_PCT;
    localparam int CPT    = CORE_CLK_KHZ / 1000;
    localparam int TPU    = TIMER_CLKS_PER_MS / 1000;
    localparam int PER_CYC = PC * CPT / TPU;

    logic              core_clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic              pwm_out_pin;
    logic              indicator_port_pin;
    logic              indicator_oe;
    logic              master_period_irq;
    logic              irq;
    int                hi_cycles;
    int                per_cycles;
    logic              led_lit;
    int                n_mismatch;
    int                checks;
    int                n_period;
    int                cycles;
    int                last_at;
    int                gap;
    int                seen;
    logic [DATA_W-1:0] rv;
    logic [DATA_W-1:0] cmp;
    logic              led_exp;

    pwm_dimmer #(
        .PERIOD_COUNT(PC),
        .UPDATE_TICKS(UT)
    ) u_pwm_dimmer (
        .core_clk          (core_clk),
        .rst               (rst),
        .addr              (addr),
        .wr_data           (wr_data),
        .wr_en             (wr_en),
        .rd_en             (rd_en),
        .rd_data           (rd_data),
        .pwm_out_pin       (pwm_out_pin),
        .indicator_port_pin(indicator_port_pin),
        .indicator_oe      (indicator_oe),
        .master_period_irq (master_period_irq),
        .irq               (irq)
    );

    led_model u_led_model (
        .core_clk  (core_clk),
        .pwm_level (pwm_out_pin),
        .ind_level (indicator_port_pin),
        .ind_oe    (indicator_oe),
        .hi_cycles (hi_cycles),
        .per_cycles(per_cycles),
        .led_lit   (led_lit)
    );

    // ------------------------------------------------------------
    // clock, period watch and timeout
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // period pulses counted and spaced
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (master_period_irq === 1'b1) begin
            n_period <= n_period + 1;
            gap      <= cycles - last_at;
            last_at  <= cycles;
        end
        if (cycles == 50000) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR timeout expected end seen hang");
            final_report;
        end
    end

    // ------------------------------------------------------------
    // bus tasks and compares
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic near(input string what, input int exp, input int got,
                        input int tol);
        checks = checks + 1;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask

    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_per(input int n);
        int t;
        t = n_period + n;
        for (int i = 0; i < 20000 && n_period < t; i++) @(posedge core_clk);
        #1;
        if (n_period < t) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR periods expected %0d seen %0d", t, n_period);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; addr = '0; wr_data = '0; wr_en = 1'b0; rd_en = 1'b0;
        n_mismatch = 0; checks = 0; n_period = 0; cycles = 0;
        last_at = 0; gap = 0; led_exp = 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        // reset state, read-only and unmapped places
        chk("pwm", 0, pwm_out_pin);
        chk("oe", 0, indicator_oe);
        chk("irq", 0, irq);
        rd(PORTDIR_OFS, rv);
        chk("portdir", {24'h000000, PORTDIR_RESET}, rv);
        @(posedge core_clk);
        #1;
        chk("rd idle", 0, rd_data);
        rd(DUTY_OFS, rv);
        chk("duty", INIT_C, rv);
        wr(DUTY_OFS, 32'h00000055);
        rd(DUTY_OFS, rv);
        chk("duty ro", INIT_C, rv);
        rd(8'h40, rv);
        chk("unmapped", 0, rv);
        $display("test reset done");
        // only bit 0 steers the indicator driver
        wr(PORTDIR_OFS, 32'h00000001);
        settle;
        chk("oe", 0, indicator_oe);
        wr(PORTDIR_OFS, 32'h000000FE);
        settle;
        chk("oe", 1, indicator_oe);
        rd(PORTDIR_OFS, rv);
        chk("portdir", 32'h000000FE, rv);
        $display("test direction done");
        // one trigger bit alone must not start
        wr(CTRL_OFS, 32'h00000001);
        settle;
        rd(CTRL_OFS, rv);
        chk("run", 0, rv & 32'h1);
        wr(CTRL_OFS, 32'h00000002);
        settle;
        rd(CTRL_OFS, rv);
        chk("run", 0, rv & 32'h1);
        chk("pwm", 0, pwm_out_pin);
        wr(CTRL_OFS, 32'h00000003);
        settle;
        chk("pwm", 1, pwm_out_pin);
        rd(CTRL_OFS, rv);
        chk("run", 1, rv & 32'h1);
        rd(ENABLE_OFS, rv);
        chk("enable", 1, rv & 32'h1);
        $display("test start done");
        // six updates walk the duty ladder through its wrap
        cmp = INIT_C;
        for (int u = 0; u < 6; u++) begin
            // new compare shows from the second period after its update
            wait_per(1);
            settle;
            chk("irq", 1, irq);
            wait_per(UT - 1);
            settle;
            near("high", cmp * CPT / TPU, hi_cycles, 10);
            near("period", PER_CYC, gap, 2);
            near("pin period", PER_CYC, per_cycles, 2);
            cmp = (cmp + STEP_C > PC) ? INIT_C : cmp + STEP_C;
            led_exp = ~led_exp;
            rd(DUTY_OFS, rv);
            chk("duty", cmp, rv);
            rd(TICK_OFS, rv);
            chk("ticks", 0, rv);
            rd(STATUS_OFS, rv);
            chk("status", 3, rv);
            chk("led", led_exp, led_lit);
            wr(CLEAR_OFS, 32'h00000003);
            settle;
            rd(STATUS_OFS, rv);
            chk("status clr", 0, rv);
            $display("test update %0d done", u);
        end
        // masking and clearing the interrupt
        wr(ENABLE_OFS, 32'h00000000);
        wait_per(1);
        settle;
        chk("irq masked", 0, irq);
        rd(STATUS_OFS, rv);
        chk("status", 1, rv & 32'h1);
        wr(ENABLE_OFS, 32'h00000001);
        settle;
        chk("irq", 1, irq);
        wr(CLEAR_OFS, 32'h00000001);
        settle;
        chk("irq clr", 0, irq);
        $display("test interrupt done");
        // stop halts both channels
        wr(CTRL_OFS, 32'h00000004);
        settle;
        chk("pwm", 0, pwm_out_pin);
        rd(CTRL_OFS, rv);
        chk("run", 0, rv & 32'h1);
        seen = n_period;
        repeat (2000) @(posedge core_clk);
        #1;
        chk("halted", seen, n_period);
        $display("test stop done");
        final_report;
    end
endmodule
